// ---- ihc_indicate_cfg.sv ----
/*
 * indicate copy control and header length configuration, with a
 * classic wishbone register slave, per-channel copy decision and the
 * header/info word split counter.
 * assumes frame_eval, frame_start, word_wr, internal_addr_match_flag,
 * frame_exclude_flag, stop_event and exception_event come from logic on
 * ref_clk; the two external match pins are asynchronous.
 */
// Implementation choice: register access over Wishbone.
// Summary of operation
// - copy mode for indicate channel two lives in bits 1:0 of copy control.
// - copy mode for indicate channel one lives in bits 4:3 of copy control.
// - copy mode for indicate channel zero lives in bits 7:6 of copy control.
// - mode 00 never copies, 01 copies on match without frame flag, 10 copies on match, 11 always.
// - an eight-bit header length in words sets the split only in header/info sort.
// - header length takes writes only while stop or exception attention is set.
// - reset leaves the header length contents unchanged.
// - the frame control byte is a word of its own and counts as one header word.
// - loading a header length below 4 raises command error and indicate stop.
// - header length has no effect outside header/info sort mode.
// - in header/info sort, header words go to channel one and the rest to channel two.
`timescale 1ns/1ps

module ihc_indicate_cfg (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic irq,
    input wire logic frame_eval,
    input wire logic internal_addr_match_flag,
    input wire logic frame_exclude_flag,
    input wire logic external_compare_pending,
    input wire logic external_copy_request,
    input wire logic stop_event,
    input wire logic exception_event,
    input wire logic frame_start,
    input wire logic word_wr,
    output logic copy_valid,
    output logic indicate_channel_zero,
    output logic indicate_channel_one,
    output logic indicate_channel_two,
    output logic header_info_active,
    output logic word_to_chan_one,
    output logic word_to_chan_two
);

    // ------------------------------------------------------------------
    // functions
    // ------------------------------------------------------------------
    function automatic logic copy_decide(
        input logic [1:0] mode,
        input logic match,
        input logic excl
    );
        logic r;
        r = 1'b0;
        case (mode)
            ihc_pkg::CM_NEVER: r = 1'b0;
            ihc_pkg::CM_MATCH_NOFLAG: r = match & ~excl;
            ihc_pkg::CM_MATCH: r = match;
            ihc_pkg::CM_ALL: r = 1'b1;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : copy_decide

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    // both pins are asynchronous: only the second stage is read
    logic [1:0] ext_meta_q;
    logic [1:0] ext_sync_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ext_meta_q <= 2'h0;
            ext_sync_q <= 2'h0;
        end else if (ce) begin
            ext_meta_q <= {external_compare_pending, external_copy_request};
            ext_sync_q <= ext_meta_q;
        end
    end

    wire ext_pending = ext_sync_q[1];
    wire ext_copy = ext_sync_q[0];

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic ack_q;
    logic [31:0] rdata_q;
    logic [7:0] copy_ctrl_q;
    logic [7:0] header_word_count;
    logic sort_hi_q;
    logic [2:0] attn_stat_q;
    logic [2:0] attn_en_q;

    wire [9:0] reg_idx = wb_adr_i[11:2];
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
    wire [7:0] wr_byte = wb_dat_i[7:0];

    wire hit_cc = (reg_idx == ihc_pkg::IDX_COPY_CTRL);
    wire hit_hl = (reg_idx == ihc_pkg::IDX_HDR_LEN);
    wire hit_sort = (reg_idx == ihc_pkg::IDX_SORT_CTRL);
    wire hit_stat = (reg_idx == ihc_pkg::IDX_ATTN_STAT);
    wire hit_clr = (reg_idx == ihc_pkg::IDX_ATTN_CLR);
    wire hit_en = (reg_idx == ihc_pkg::IDX_ATTN_EN);

    wire wr_cc = bus_wr & hit_cc;
    wire wr_sort = bus_wr & hit_sort;
    wire wr_clr = bus_wr & hit_clr;
    wire wr_en = bus_wr & hit_en;

    // header length open only in stop or exception state
    wire hl_open = attn_stat_q[ihc_pkg::ATTN_STOP_BIT]
        | attn_stat_q[ihc_pkg::ATTN_EXCEPT_BIT];
    wire wr_hl = bus_wr & hit_hl & hl_open;
    // short values are stored and flagged on the same edge
    wire hl_too_small = wr_byte < ihc_pkg::HDR_LEN_MIN;
    wire hl_error = wr_hl & hl_too_small;

    // reserved bits 2 and 5 held at zero
    wire [7:0] cc_d = wr_byte & ihc_pkg::CC_WR_MASK;

    // clear register and unmapped indices read as zero
    wire [31:0] rd_mux =
        hit_cc ? {24'h000000, copy_ctrl_q} :
        hit_hl ? {24'h000000, header_word_count} :
        hit_sort ? {31'h00000000, sort_hi_q} :
        hit_stat ? {29'h00000000, attn_stat_q} :
        hit_en ? {29'h00000000, attn_en_q} :
        32'h00000000;

    // ------------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------------
    // ack_q gate: a held strobe is taken every other cycle
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ack_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else if (ce) begin
            ack_q <= bus_req;
            rdata_q <= bus_req ? rd_mux : 32'h00000000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            copy_ctrl_q <= ihc_pkg::CC_RESET;
            sort_hi_q <= ihc_pkg::SORT_RESET;
            attn_en_q <= ihc_pkg::ATTN_RESET;
        end else if (ce) begin
            if (wr_cc)
                copy_ctrl_q <= cc_d;
            if (wr_sort)
                sort_hi_q <= wr_byte[ihc_pkg::SORT_HDR_INFO_BIT];
            if (wr_en)
                attn_en_q <= wr_byte[2:0];
        end
    end

    // no reset: contents survive a reset
    always_ff @(posedge ref_clk) begin
        if (ce && wr_hl)
            header_word_count <= wr_byte;
    end

    // ------------------------------------------------------------------
    // attention status, clear and interrupt
    // ------------------------------------------------------------------
    // bit 0 command error, bit 1 stop, bit 2 exception
    logic [2:0] attn_set;
    logic [2:0] attn_clr;
    logic [2:0] attn_d;
    logic irq_q;

    always_comb begin
        attn_set = 3'h0;
        attn_set[ihc_pkg::ATTN_CMD_ERR_BIT] = hl_error;
        attn_set[ihc_pkg::ATTN_STOP_BIT] = hl_error | stop_event;
        attn_set[ihc_pkg::ATTN_EXCEPT_BIT] = exception_event;
        attn_clr = wr_clr ? wr_byte[2:0] : 3'h0;
        // a set in the clearing cycle wins
        attn_d = (attn_stat_q & ~attn_clr) | attn_set;
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            attn_stat_q <= ihc_pkg::ATTN_RESET;
            irq_q <= 1'b0;
        end else if (ce) begin
            attn_stat_q <= attn_d;
            irq_q <= |(attn_d & attn_en_q);
        end
    end

    // built from the next status, so irq rises with the bit
    assign irq = irq_q;

    // ------------------------------------------------------------------
    // copy decision per channel
    // ------------------------------------------------------------------
    // fields of the copy control register
    wire [1:0] mode_two = copy_ctrl_q[ihc_pkg::CC_TWO_LSB +: 2];
    wire [1:0] mode_one = copy_ctrl_q[ihc_pkg::CC_ONE_LSB +: 2];
    wire [1:0] mode_zero = copy_ctrl_q[ihc_pkg::CC_ZERO_LSB +: 2];

    // match term shared by all three channels
    wire addr_hit = internal_addr_match_flag
        | (~ext_pending & ext_copy);
    // fields indexed by channel number, lowest channel first
    wire [5:0] mode_by_chan = {mode_two, mode_one, mode_zero};
    logic [2:0] cp_chan;

    for (genvar ch = 0; ch < 3; ch++) begin : g_chan
        assign cp_chan[ch] = copy_decide(mode_by_chan[2 * ch +: 2],
            addr_hit, frame_exclude_flag);
    end

    logic copy_valid_q;
    logic [2:0] copy_chan_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            copy_valid_q <= 1'b0;
            copy_chan_q <= 3'h0;
        end else if (ce) begin
            copy_valid_q <= frame_eval;
            if (frame_eval)
                copy_chan_q <= cp_chan;
        end
    end

    assign copy_valid = copy_valid_q;
    assign indicate_channel_zero = copy_chan_q[0];
    assign indicate_channel_one = copy_chan_q[1];
    assign indicate_channel_two = copy_chan_q[2];

    // ------------------------------------------------------------------
    // header/info word split
    // ------------------------------------------------------------------
    // one-hot split states
    typedef enum logic [2:0] {
        SPLIT_IDLE = 3'b001,
        SPLIT_HEADER = 3'b010,
        SPLIT_INFO = 3'b100
    } ihc_split_e;

    ihc_split_e split_q;
    ihc_split_e split_d;
    logic [7:0] word_cnt_q;
    logic [7:0] word_cnt_d;
    logic to_one_q;
    logic to_two_q;

    // fc word is word one, so header ends when count reaches length
    wire [7:0] cnt_next = word_cnt_q + 8'h01;
    wire hdr_done = (cnt_next >= header_word_count);
    wire split_on = sort_hi_q;

    always_comb begin
        split_d = split_q;
        word_cnt_d = word_cnt_q;
        case (split_q)
            SPLIT_IDLE: begin
                word_cnt_d = 8'h00;
                if (frame_start && split_on)
                    split_d = SPLIT_HEADER;
            end
            SPLIT_HEADER: begin
                if (frame_start) begin
                    word_cnt_d = 8'h00;
                end else if (word_wr) begin
                    word_cnt_d = cnt_next;
                    if (hdr_done)
                        split_d = SPLIT_INFO;
                end
            end
            SPLIT_INFO: begin
                if (frame_start) begin
                    word_cnt_d = 8'h00;
                    split_d = SPLIT_HEADER;
                end
            end
            default: begin
                split_d = SPLIT_IDLE;
                word_cnt_d = 8'h00;
            end
        endcase
        // sort bit low sends the machine home
        if (!split_on)
            split_d = SPLIT_IDLE;
    end

    // a word in the frame_start cycle belongs to no frame
    wire word_in_hdr = word_wr & (split_q == SPLIT_HEADER) & ~frame_start;
    wire word_in_info = word_wr & (split_q == SPLIT_INFO) & ~frame_start;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            split_q <= SPLIT_IDLE;
            word_cnt_q <= 8'h00;
            to_one_q <= 1'b0;
            to_two_q <= 1'b0;
        end else if (ce) begin
            split_q <= split_d;
            word_cnt_q <= word_cnt_d;
            to_one_q <= word_in_hdr & split_on;
            to_two_q <= word_in_info & split_on;
        end
    end

    // sort bit mirrored outside, one cycle late
    logic hi_active_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst)
            hi_active_q <= 1'b0;
        else if (ce)
            hi_active_q <= sort_hi_q;
    end

    assign header_info_active = hi_active_q;
    assign word_to_chan_one = to_one_q;
    assign word_to_chan_two = to_two_q;

endmodule : ihc_indicate_cfg

// ---- ihc_indicate_cfg_assertions.sv ----
/*
 * port-level checks for the indicate copy and header length block.
 * assumes byte lane 0 is enabled on every write.
 */
`timescale 1ns/1ps

module ihc_assertions (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic frame_eval,
    input wire logic internal_addr_match_flag,
    input wire logic frame_exclude_flag,
    input wire logic frame_start,
    input wire logic word_wr,
    input wire logic indicate_channel_zero,
    input wire logic indicate_channel_one,
    input wire logic indicate_channel_two,
    input wire logic header_info_active,
    input wire logic word_to_chan_one,
    input wire logic word_to_chan_two
);
    // ------------------------------------------------------------------
    // shadow of the copy control register
    // ------------------------------------------------------------------
    logic [7:0] cc_q;
    wire wr_cc = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & ce
        & wb_sel_i[0] & (wb_adr_i == 12'h460);
    wire ev = frame_eval & ce;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cc_q <= 8'h00;
        end else if (wr_cc) begin
            cc_q <= wb_dat_i[7:0];
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    sequence s_hit;
        ev && internal_addr_match_flag;
    endsequence
    sequence s_fc;
        header_info_active && frame_start ##1 !word_wr ##1 word_wr;
    endsequence

    a_ch_two_all: assert property (ev && cc_q[1:0] == 2'h3
        |=> indicate_channel_two) else $error("channel two missed");
    a_ch_one_never: assert property (ev && cc_q[4:3] == 2'h0
        |=> !indicate_channel_one) else $error("channel one copied");
    a_ch_zero_all: assert property (ev && cc_q[7:6] == 2'h3
        |=> indicate_channel_zero) else $error("channel zero missed");
    a_match_copies: assert property (s_hit ##0 cc_q[1:0] == 2'h2
        |=> indicate_channel_two) else $error("match not copied");
    a_excl_blocks: assert property (ev && frame_exclude_flag
        && cc_q[4:3] == 2'h1 |=> !indicate_channel_one)
        else $error("excluded frame copied");
    a_reserved_zero: assert property (wb_ack_o && !wb_we_i
        && wb_adr_i == 12'h460 |-> !wb_dat_o[2] && !wb_dat_o[5])
        else $error("reserved bit reads one");
    a_no_split_idle: assert property (!header_info_active[*2]
        |-> !word_to_chan_one && !word_to_chan_two)
        else $error("split pulse outside sort mode");
    a_fc_header: assert property (s_fc |=> word_to_chan_one)
        else $error("first word not on header channel");

endmodule : ihc_assertions

// ---- ihc_pkg.sv ----
/*
 * constants for the indicate copy and header length configuration block:
 * register indices, field positions, reset values and status layout.
 * assumes a 32-bit classic wishbone slave with word-aligned registers.
 */
package ihc_pkg;

    // ------------------------------------------------------------------
    // register indices (byte address = index * 4)
    // ------------------------------------------------------------------
    localparam logic [9:0] IDX_COPY_CTRL = 10'h118;
    localparam logic [9:0] IDX_HDR_LEN = 10'h119;
    localparam logic [9:0] IDX_SORT_CTRL = 10'h11C;
    localparam logic [9:0] IDX_ATTN_STAT = 10'h11D;
    localparam logic [9:0] IDX_ATTN_CLR = 10'h11E;
    localparam logic [9:0] IDX_ATTN_EN = 10'h11F;

    // ------------------------------------------------------------------
    // copy control fields
    // ------------------------------------------------------------------
    localparam int CC_TWO_LSB = 0;
    localparam int CC_ONE_LSB = 3;
    localparam int CC_ZERO_LSB = 6;
    localparam logic [7:0] CC_WR_MASK = 8'hDB;
    localparam logic [7:0] CC_RESET = 8'h00;

    // copy mode encodings
    localparam logic [1:0] CM_NEVER = 2'h0;
    localparam logic [1:0] CM_MATCH_NOFLAG = 2'h1;
    localparam logic [1:0] CM_MATCH = 2'h2;
    localparam logic [1:0] CM_ALL = 2'h3;

    // ------------------------------------------------------------------
    // header length
    // ------------------------------------------------------------------
    localparam logic [7:0] HDR_LEN_MIN = 8'h04;

    // ------------------------------------------------------------------
    // sort control and attention status bits
    // ------------------------------------------------------------------
    localparam int SORT_HDR_INFO_BIT = 0;
    localparam logic SORT_RESET = 1'b0;
    localparam int ATTN_CMD_ERR_BIT = 0;
    localparam int ATTN_STOP_BIT = 1;
    localparam int ATTN_EXCEPT_BIT = 2;
    localparam int ATTN_W = 3;
    localparam logic [2:0] ATTN_RESET = 3'h0;

endpackage : ihc_pkg

// ---- tb_ihc_indicate_cfg.sv ----
/*
 * self-checking bench for the indicate copy and header length block.
 * assumes the package, the design and the checker are compiled first.
 */
`timescale 1ns/1ps

module tb_ihc_indicate_cfg;
    logic ref_clk = 0, nrst = 0, ce = 1, wb_cyc_i = 0, wb_stb_i = 0;
    logic wb_we_i = 0, frame_eval = 0, internal_addr_match_flag = 0;
    logic frame_exclude_flag = 0, external_compare_pending = 0;
    logic external_copy_request = 0, stop_event = 0, exception_event = 0;
    logic frame_start = 0, word_wr = 0, wb_ack_o, irq, copy_valid;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, rd, wb_dat_o;
    logic indicate_channel_zero, indicate_channel_one, indicate_channel_two;
    logic header_info_active, word_to_chan_one, word_to_chan_two;
    int failures = 0, num_checks = 0, cycles = 0, n1 = 0, n2 = 0;

    ihc_indicate_cfg dut_u (.ref_clk, .nrst, .ce, .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq,
        .frame_eval, .internal_addr_match_flag, .frame_exclude_flag,
        .external_compare_pending, .external_copy_request, .stop_event,
        .exception_event, .frame_start, .word_wr, .copy_valid,
        .indicate_channel_zero, .indicate_channel_one, .indicate_channel_two,
        .header_info_active, .word_to_chan_one, .word_to_chan_two);

    // ------------------------------------------------------------------
    // clock, timeout and split pulse counters
    // ------------------------------------------------------------------
    initial forever #12.5 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    always @(negedge ref_clk) begin
        if (word_to_chan_one === 1'h1) n1++;
        if (word_to_chan_two === 1'h1) n2++;
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic wb(input logic we, input logic [11:0] a,
                      input logic [31:0] d);
        @(posedge ref_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        @(posedge ref_clk);
        while (wb_ack_o !== 1'h1) @(posedge ref_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask : wb

    // p: eval, word, start, exception, stop
    task automatic pulse(input logic [4:0] p);
        @(posedge ref_clk);
        {frame_eval, word_wr, frame_start, exception_event, stop_event} <= p;
        @(posedge ref_clk);
        {frame_eval, word_wr, frame_start, exception_event, stop_event} <= 0;
    endtask : pulse

    function automatic logic exp_cp(input logic [1:0] m, input logic [3:0] f);
        logic mt;
        mt = f[0] | (f[2] & ~f[3]);
        return (m == 2'h3) | (m == 2'h2 & mt) | (m == 2'h1 & mt & ~f[1]);
    endfunction : exp_cp

    task automatic eval(input logic [3:0] f);
        @(posedge ref_clk);
        internal_addr_match_flag <= f[0];
        frame_exclude_flag <= f[1];
        external_copy_request <= f[2];
        external_compare_pending <= f[3];
        repeat (3) @(posedge ref_clk);
        pulse(5'h10);
        @(negedge ref_clk);
    endtask : eval

    task automatic frame(input int e1, input int e2);
        n1 = 0;
        n2 = 0;
        pulse(5'h04);
        repeat (8) pulse(5'h08);
        repeat (2) @(posedge ref_clk);
        check(32'(n1), 32'(e1));
        check(32'(n2), 32'(e2));
    endtask : frame

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_regs;
        wb(1'h0, 12'h460, 32'h0);
        check(rd, 32'h0);
        wb(1'h1, 12'h460, 32'hFF);
        wb(1'h0, 12'h460, 32'h0);
        check(rd, 32'hDB);
        wb(1'h1, 12'h500, 32'hFF);
        wb(1'h0, 12'h500, 32'h0);
        check(rd, 32'h0);
        wb(1'h0, 12'h478, 32'h0);
        check(rd, 32'h0);
    endtask : t_regs

    task automatic t_copy;
        logic [1:0] m;
        logic [3:0] g;
        logic [2:0] e;
        for (int i = 0; i < 4; i++) begin
            m = 2'(i);
            wb(1'h1, 12'h460, {24'h0, m, 1'h0, m + 2'h1, 1'h0, m + 2'h2});
            for (int f = 0; f < 16; f++) begin
                g = 4'(f);
                e = {exp_cp(m, g), exp_cp(m + 2'h1, g), exp_cp(m + 2'h2, g)};
                eval(g);
                check(32'(copy_valid), 32'h1);
                check(32'(indicate_channel_zero), 32'(e[2]));
                check(32'(indicate_channel_one), 32'(e[1]));
                check(32'(indicate_channel_two), 32'(e[0]));
            end
        end
    endtask : t_copy

    task automatic t_hdr;
        wb(1'h1, 12'h47C, 32'h7);
        pulse(5'h01);
        wb(1'h0, 12'h474, 32'h0);
        check(rd, 32'h2);
        check(32'(irq), 32'h1);
        wb(1'h1, 12'h464, 32'h6);
        wb(1'h1, 12'h478, 32'h7);
        wb(1'h1, 12'h464, 32'h9);
        wb(1'h0, 12'h464, 32'h0);
        check(rd, 32'h6);
        check(32'(irq), 32'h0);
        @(posedge ref_clk);
        nrst <= 1'h0;
        repeat (2) @(posedge ref_clk);
        nrst <= 1'h1;
        wb(1'h0, 12'h464, 32'h0);
        check(rd, 32'h6);
        wb(1'h0, 12'h47C, 32'h0);
        check(rd, 32'h0);
        pulse(5'h02);
        wb(1'h1, 12'h464, 32'h3);
        wb(1'h0, 12'h474, 32'h0);
        check(rd, 32'h7);
        check(32'(irq), 32'h0);
        wb(1'h1, 12'h464, 32'h6);
        wb(1'h1, 12'h478, 32'h7);
        check(32'(header_info_active), 32'h0);
        frame(0, 0);
        wb(1'h1, 12'h470, 32'h1);
        @(negedge ref_clk);
        check(32'(header_info_active), 32'h1);
        frame(6, 2);
        ce <= 1'h0;
        pulse(5'h01);
        ce <= 1'h1;
        wb(1'h0, 12'h474, 32'h0);
        check(rd, 32'h0);
    endtask : t_hdr

    initial begin
        repeat (6) @(posedge ref_clk);
        nrst <= 1'h1;
        t_regs();
        t_copy();
        t_hdr();
        report_and_stop();
    end

endmodule : tb_ihc_indicate_cfg

bind ihc_indicate_cfg ihc_assertions chk_u (.ref_clk, .nrst, .ce, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .frame_eval, .internal_addr_match_flag, .frame_exclude_flag,
    .frame_start, .word_wr, .indicate_channel_zero, .indicate_channel_one,
    .indicate_channel_two, .header_info_active, .word_to_chan_one,
    .word_to_chan_two);
